// ---- hdl/sgp_pkg.sv ----
package sgp_pkg;
	localparam int          BUS_W        = 8;
	localparam int          REG_CNT      = 16;
	localparam int          IDX_W        = 4;
	localparam logic [3:0]  CS_NIBBLE    = 4'h0;
	localparam logic        SEL_LOW_OK   = 1'b0;
	localparam logic        SEL_HIGH_OK  = 1'b1;
	localparam logic [7:0]  REG_RESET    = 8'h00;
	localparam logic [7:0]  AMP_MASK     = 8'h3f;
	localparam logic [7:0]  FULL_MASK    = 8'hff;
	localparam logic [3:0]  AMP_FIRST    = 4'h8;
	localparam logic [3:0]  AMP_LAST     = 4'ha;
	localparam int          NOISE_W      = 17;
	localparam int          CNT_W        = 16;
	localparam logic [2:0]  NOISE_TAP_A  = 3'h0;
	localparam logic [2:0]  NOISE_TAP_B  = 3'h3;

	// bus direction / primary control pair
	typedef enum logic [1:0] {
		SGP_IDLE  = 2'b00,
		SGP_READ  = 2'b01,
		SGP_WRITE = 2'b10,
		SGP_LATCH = 2'b11
	} sgp_code_t;

	// host sequencer states, gray from HS_IDLE through HS_DONE
	typedef enum logic [2:0] {
		HS_IDLE  = 3'b000,
		HS_ADDR  = 3'b001,
		HS_GAP   = 3'b011,
		HS_DATA  = 3'b010,
		HS_XFER  = 3'b110,
		HS_DONE  = 3'b111
	} sgp_hstate_t;

	function automatic logic [7:0] sgp_store_mask(input logic [3:0] idx);
		if (idx >= AMP_FIRST && idx <= AMP_LAST)
			return AMP_MASK;
		return FULL_MASK;
	endfunction : sgp_store_mask
endpackage : sgp_pkg

// ---- hdl/sgp_bus_if.sv ----
`timescale 1ns/1ps
interface sgp_bus_if;
	import sgp_pkg::*;
	logic [7:0] dev_dout;
	logic [7:0] dev_oe_n;
	logic [7:0] host_dout;
	logic [7:0] host_oe_n;
	logic [7:0] bus_din;
	logic       bus_direction_line;
	logic       bus_control_primary;
	logic       bus_control_unused;
	logic       upper_select_low_active;
	logic       upper_select_high_active;

	modport device (
		input  bus_din, bus_direction_line, bus_control_primary,
		input  bus_control_unused, upper_select_low_active,
		input  upper_select_high_active,
		output dev_dout, dev_oe_n
	);
	modport host (
		input  bus_din,
		output host_dout, host_oe_n, bus_direction_line,
		output bus_control_primary, bus_control_unused,
		output upper_select_low_active, upper_select_high_active
	);
endinterface : sgp_bus_if

// ---- hdl/sgp_gen_core.sv ----
`timescale 1ns/1ps
module sgp_gen_core
	import sgp_pkg::*;
#(
	parameter int NW = NOISE_W,
	parameter int CW = CNT_W
) (
	// clock and reset
	input  wire logic          clk,
	input  wire logic          nrst,
	input  wire logic          tick,
	// period from the register file
	input  wire logic [7:0]    noise_period,
	// state seen by the device
	output logic [NW-1:0]      noise_shift,
	output logic               noise_value,
	output logic [CW-1:0]      work_cnt
);
	always_ff @(posedge clk) begin
		if (!nrst) begin
			work_cnt <= '0;
		end else if (tick) begin
			if (work_cnt[7:0] >= noise_period)
				work_cnt <= '0;
			else
				work_cnt <= work_cnt + CW'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			noise_shift <= '1;
			noise_value <= 1'b0;
		end else if (tick && work_cnt[7:0] >= noise_period) begin
			noise_shift <= {noise_shift[0] ^ noise_shift[NOISE_TAP_B],
				noise_shift[NW-1:1]};
			noise_value <= noise_shift[NOISE_TAP_A];
		end
	end
endmodule : sgp_gen_core

// ---- hdl/sgp_device.sv ----
// Operation
// - idle code floats bus, no action
// - read code drives addressed register out
// - write code latches bus into register
// - latch code captures address, bus input
// - eight-bit muxed bus, low nibble selects
// - select pins must present code 01
// - deselected: bus floats, accesses ignored
// - reset clears all registers to zero
// - missing bits read back as zero
// - some expanded bits undefined after reset
// - reset clears generator counters
// - reset sets noise shifter all ones
// - reset clears noise output value
// - divide select low halves clock
// - unconnected divide select means undivided; here an open CLK_DIV_SEL has no pull-up and floats
// - every register readable by host
// - host drives only direction and primary; here sgp_host also holds bus_control_unused low
// - main clock times generators only; here CLK also clocks the address latch and register writes
// - bus access independent of clock rate
// - address held until next latch code
// - upper four address bits must be zero
// - write follows idle, data, write, idle
`timescale 1ns/1ps
module sgp_device
	import sgp_pkg::*;
#(
	parameter int NREG = REG_CNT
) (
	// clock and reset
	input  wire logic         CLK,
	input  wire logic         NRST,
	// clock divide select, floats when left open (no pull-up)
	input  wire logic         CLK_DIV_SEL,
	// host bus
	sgp_bus_if.device         BUS,
	// generator state
	output logic              NOISE_VALUE,
	output logic [NOISE_W-1:0] NOISE_SHIFT
);
	logic [7:0]      regs [NREG];
	logic [7:0]      addr_reg;
	logic            half_reg;
	logic            tick;
	logic            chip_sel;
	logic [1:0]      code;
	logic [IDX_W-1:0] idx;
	logic [CNT_W-1:0] work_cnt;

	// bus_control_unused is deliberately not read
	assign code = {BUS.bus_direction_line, BUS.bus_control_primary};
	assign idx  = addr_reg[IDX_W-1:0];
	// select pins are combined with the latched upper nibble
	assign chip_sel = BUS.upper_select_low_active == SEL_LOW_OK
		&& BUS.upper_select_high_active == SEL_HIGH_OK
		&& addr_reg[7:4] == CS_NIBBLE;

	// address latch; the upper nibble is kept so that a later
	// mismatch deselects the part
	always_ff @(posedge CLK) begin
		if (!NRST)
			addr_reg <= REG_RESET;
		else if (code == SGP_LATCH && BUS.upper_select_low_active == SEL_LOW_OK
			&& BUS.upper_select_high_active == SEL_HIGH_OK)
			addr_reg <= BUS.bus_din;
	end

	// registers: writes gated by chip select, missing bits kept zero
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			for (int i = 0; i < NREG; i++)
				regs[i] <= REG_RESET;
		end else if (code == SGP_WRITE && chip_sel) begin
			// expanded bank is not modelled, so loose bits are stored as zero
			regs[idx] <= BUS.bus_din & sgp_store_mask(idx);
		end
	end

	// read path is combinational from the control levels so the
	// bus works at any generator clock rate
	always_comb begin
		BUS.dev_dout = regs[idx];
		if (code == SGP_READ && chip_sel)
			BUS.dev_oe_n = 8'h00;
		else
			BUS.dev_oe_n = 8'hff;
	end

	// divider: select high is undivided; an open select floats, there is no pull-up
	always_ff @(posedge CLK) begin
		if (!NRST)
			half_reg <= 1'b0;
		else
			half_reg <= ~half_reg;
	end
	assign tick = CLK_DIV_SEL ? 1'b1 : half_reg;

	sgp_gen_core u_gen (
		.clk          (CLK),
		.nrst         (NRST),
		.tick         (tick),
		.noise_period (regs[6]),
		.noise_shift  (NOISE_SHIFT),
		.noise_value  (NOISE_VALUE),
		.work_cnt     (work_cnt)
	);
endmodule : sgp_device

// ---- hdl/sgp_host.sv ----
`timescale 1ns/1ps
module sgp_host
	import sgp_pkg::*;
(
	// clock and reset
	input  wire logic       CLK,
	input  wire logic       NRST,
	// user request
	input  wire logic       REQ_VALID,
	input  wire logic       REQ_WRITE,
	input  wire logic [3:0] REQ_ADDR,
	input  wire logic [7:0] REQ_WDATA,
	output logic            REQ_READY,
	output logic            RSP_VALID,
	output logic [7:0]      RSP_RDATA,
	// device bus
	sgp_bus_if.host         BUS
);
	sgp_hstate_t st_reg;
	logic        wr_reg;
	logic [7:0]  a_reg;
	logic [7:0]  d_reg;

	assign REQ_READY = st_reg == HS_IDLE;
	assign BUS.upper_select_low_active  = SEL_LOW_OK;
	assign BUS.upper_select_high_active = SEL_HIGH_OK;
	assign BUS.bus_control_unused = 1'b0;

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			st_reg <= HS_IDLE;
			wr_reg <= 1'b0;
			a_reg  <= REG_RESET;
			d_reg  <= REG_RESET;
		end else begin
			case (st_reg)
			HS_IDLE: begin
				if (REQ_VALID) begin
					wr_reg <= REQ_WRITE;
					a_reg  <= {CS_NIBBLE, REQ_ADDR};
					d_reg  <= REQ_WDATA;
					st_reg <= HS_ADDR;
				end
			end
			HS_ADDR: st_reg <= HS_GAP;
			HS_GAP:  st_reg <= HS_DATA;
			HS_DATA: st_reg <= HS_XFER;
			HS_XFER: st_reg <= HS_DONE;
			HS_DONE: st_reg <= HS_IDLE;
			default: st_reg <= HS_IDLE;
			endcase
		end
	end

	// bus levels per state: latch, idle, data set-up, transfer, idle
	always_comb begin
		BUS.bus_direction_line  = 1'b0;
		BUS.bus_control_primary = 1'b0;
		BUS.host_dout = a_reg;
		BUS.host_oe_n = 8'hff;
		case (st_reg)
		HS_ADDR: begin
			BUS.bus_direction_line  = 1'b1;
			BUS.bus_control_primary = 1'b1;
			BUS.host_oe_n = 8'h00;
		end
		HS_DATA: begin
			BUS.host_dout = d_reg;
			BUS.host_oe_n = wr_reg ? 8'h00 : 8'hff;
		end
		HS_XFER: begin
			BUS.host_dout = d_reg;
			if (wr_reg) begin
				BUS.bus_direction_line = 1'b1;
				BUS.host_oe_n = 8'h00;
			end else begin
				BUS.bus_control_primary = 1'b1;
			end
		end
		default: begin
			BUS.host_oe_n = 8'hff;
		end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			RSP_VALID <= 1'b0;
			RSP_RDATA <= REG_RESET;
		end else begin
			RSP_VALID <= st_reg == HS_XFER;
			if (st_reg == HS_XFER && !wr_reg)
				RSP_RDATA <= BUS.bus_din;
		end
	end
endmodule : sgp_host

// ---- tb/sgp_bus_checker.sv ----
`timescale 1ns/1ps
module sgp_bus_checker
	import sgp_pkg::*;
(
	// clock and reset
	input wire logic       CLK,
	input wire logic       NRST,
	// bus wires
	input wire logic [7:0] dev_dout,
	input wire logic [7:0] dev_oe_n,
	input wire logic [7:0] host_oe_n,
	input wire logic [7:0] bus_din,
	// controls
	input wire logic       bus_direction_line,
	input wire logic       bus_control_primary,
	input wire logic       bus_control_unused,
	input wire logic       upper_select_low_active,
	input wire logic       upper_select_high_active
);
	logic [1:0] code;
	logic       sel_ok;
	logic [7:0] adr_reg;

	assign code = {bus_direction_line, bus_control_primary};
	assign sel_ok = !upper_select_low_active && upper_select_high_active;

	// own copy of the latched address, for the chip-select part
	always_ff @(posedge CLK) begin
		if (!NRST)
			adr_reg <= 8'h00;
		else if (code == 2'h3 && sel_ok)
			adr_reg <= bus_din;
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);

	a_idle_floats: assert property (code == 2'h0 |-> dev_oe_n == 8'hff)
		else $error("device drives while idle");
	a_read_drives: assert property (code == 2'h1 && sel_ok &&
		adr_reg[7:4] == 4'h0 |-> dev_oe_n == 8'h00)
		else $error("read code not answered");
	a_read_stable: assert property (code == 2'h1 && $past(code) == 2'h1
		|-> $stable(dev_dout))
		else $error("read data moved");
	a_write_floats: assert property (code == 2'h2 |-> dev_oe_n == 8'hff)
		else $error("device drives during write");
	a_latch_floats: assert property (code == 2'h3 |-> dev_oe_n == 8'hff)
		else $error("device drives during latch");
	a_no_fight: assert property ((~dev_oe_n & ~host_oe_n) == 8'h00)
		else $error("both ends drive the bus");
	a_write_then_idle: assert property (code == 2'h2 |=> code == 2'h0)
		else $error("write not followed by idle");
	a_unused_low: assert property (bus_control_unused == 1'b0)
		else $error("unused control moved");
endmodule : sgp_bus_checker

// ---- tb/sound_generator_host_bus_port_test.sv ----
`timescale 1ns/1ps
module sound_generator_host_bus_port_test;
	import sgp_pkg::*;
	logic        CLK = 0, NRST = 0, vld = 0, wr = 0, rdy, rsp, nv;
	logic [3:0]  adr = 0;
	logic [7:0]  wd = 0, rd, m;
	logic [16:0] ns;
	int          err_count = 0, n_checks = 0, i, c;
	sgp_bus_if a();
	sgp_bus_if b();

	// a released bus toggles so a stale value never passes for data
	assign a.bus_din = (~a.dev_oe_n & a.dev_dout) | (~a.host_oe_n & a.host_dout)
		| (a.dev_oe_n & a.host_oe_n & {8{CLK}});
	assign b.bus_din = (~b.dev_oe_n & b.dev_dout) | (~b.host_oe_n & b.host_dout)
		| (b.dev_oe_n & b.host_oe_n & {8{CLK}});
	always #5 CLK = ~CLK;

	sgp_device u_sgp_device(.CLK(CLK), .NRST(NRST), .CLK_DIV_SEL(1'b1),
		.BUS(a), .NOISE_VALUE(nv), .NOISE_SHIFT(ns));
	sgp_device u_sgp_device_b(.CLK(CLK), .NRST(NRST), .CLK_DIV_SEL(1'b0),
		.BUS(b), .NOISE_VALUE(), .NOISE_SHIFT());
	sgp_host u_sgp_host(.CLK(CLK), .NRST(NRST), .REQ_VALID(vld),
		.REQ_WRITE(wr), .REQ_ADDR(adr), .REQ_WDATA(wd), .REQ_READY(rdy),
		.RSP_VALID(rsp), .RSP_RDATA(rd), .BUS(a));
	sgp_bus_checker u_sgp_bus_checker(.CLK(CLK), .NRST(NRST),
		.dev_dout(a.dev_dout), .dev_oe_n(a.dev_oe_n), .host_oe_n(a.host_oe_n),
		.bus_din(a.bus_din), .bus_direction_line(a.bus_direction_line),
		.bus_control_primary(a.bus_control_primary),
		.bus_control_unused(a.bus_control_unused),
		.upper_select_low_active(a.upper_select_low_active),
		.upper_select_high_active(a.upper_select_high_active));

	task chk(input string nm, input logic [16:0] s, e);
		n_checks++;
		if (s !== e) begin
			err_count++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask : chk

	task xfer(input logic w, input logic [3:0] ad, input logic [7:0] d);
		c = 0;
		while (rdy !== 1'b1 && c < 20) begin
			@(posedge CLK);
			#1 c++;
		end
		vld = 1;
		wr = w;
		adr = ad;
		wd = d;
		@(posedge CLK);
		#1 vld = 0;
		c = 1;
		while (rsp !== 1'b1 && c < 20) begin
			@(posedge CLK);
			#1 c++;
		end
		chk("latency", c, 5);
	endtask : xfer

	// raw bus step on the second pair, host side played by hand
	task raw(input sgp_code_t k, input logic [7:0] d);
		@(posedge CLK);
		#1 {b.bus_direction_line, b.bus_control_primary} = k;
		b.host_dout = d;
		b.host_oe_n = k[1] ? 8'h00 : 8'hff;
	endtask : raw

	task desel;
		raw(SGP_LATCH, 8'h13);
		raw(SGP_IDLE, 8'h00);
		raw(SGP_WRITE, 8'h55);
		raw(SGP_IDLE, 8'h00);
		raw(SGP_READ, 8'h00);
		#1 chk("desel", b.dev_oe_n, 8'hff);
		raw(SGP_IDLE, 8'h00);
		raw(SGP_LATCH, 8'h03);
		raw(SGP_IDLE, 8'h00);
		raw(SGP_READ, 8'h00);
		#1 chk("oe", b.dev_oe_n, 8'h00);
		chk("ignored", b.dev_dout, 8'h00);
		b.upper_select_low_active = 1;
		#1 chk("pins", b.dev_oe_n, 8'hff);
		b.upper_select_low_active = 0;
		raw(SGP_IDLE, 8'h00);
	endtask : desel

	task report_and_stop;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop

	initial begin
		#100000;
		err_count++;
		report_and_stop;
	end

	initial begin
		b.host_oe_n = 8'hff;
		b.host_dout = 8'h00;
		{b.bus_direction_line, b.bus_control_primary} = 2'h0;
		b.bus_control_unused = 0;
		b.upper_select_low_active = 0;
		b.upper_select_high_active = 1;
		repeat (8) @(posedge CLK);
		#1 chk("shift", ns, 17'h1ffff);
		chk("nval", nv, 17'h0);
		NRST = 1;
		for (i = 0; i < 16; i++) begin
			xfer(0, i[3:0], 8'h00);
			chk("reset", rd, 17'h0);
		end
		// write then read straight back, amplitude places lose the top bits
		for (i = 0; i < 16; i++) begin
			xfer(1, i[3:0], 8'hc3 ^ i[7:0]);
			xfer(0, i[3:0], 8'h00);
			m = (i >= 8 && i <= 10) ? 8'h3f : 8'hff;
			chk("readback", rd, (8'hc3 ^ i[7:0]) & m);
		end
		desel;
		report_and_stop;
	end
endmodule : sound_generator_host_bus_port_test
